// ===== periph_irq_flags.sv
// Peripheral interrupt flag register with mask and one interrupt line.
// Assumes peripheral event inputs are one-cycle pulses on ref_clk,
// buffer states are levels, and software uses Avalon-MM.
//
// Operation
// R1 - Bit 7 sets on each completed parallel slave port access and stays.
// R2 - Bit 6 sets when a conversion finishes; zero means none completed.
// R3 - Bit 5 reads one while the receive buffer holds data, else zero.
// R4 - Bit 4 reads one while the transmit buffer is empty, else zero.
// R5 - Bit 3 sets on an SPI or I2C slave transfer; software clears it.
// R6 - As I2C master, bit 3 also sets on transfer and own bus sequences.
// R7 - As I2C master, bit 3 sets on a bus START or STOP while port idle.
// R8 - In capture mode, bit 2 sets on each timer A capture and stays.
// R9 - In compare mode, bit 2 sets on a match; PWM mode leaves it unused.
// R10 - Bit 1 sets when timer B count equals its period and stays.
// R11 - Bit 0 sets when the 16-bit timer A count overflows and stays.
// R12 - Flags set regardless of any individual or global enable.
// R13 - Software clears a flag before enabling its interrupt.
// R14 - An event in the same cycle as its clear still sets the flag.
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module periph_irq_flags #(
   parameter int addr_w = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,

   // Avalon-MM slave
   input wire logic [addr_w-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,

   // Parallel slave port and converter
   input wire logic parallel_access_done,
   input wire logic conversion_done,

   // Serial port buffer states
   input wire logic rx_buffer_full,
   input wire logic tx_buffer_empty,

   // Synchronous serial port events
   input wire logic spi_xfer_done,
   input wire logic i2c_slave_xfer_done,
   input wire logic i2c_master_mode,
   input wire logic i2c_master_xfer_done,
   input wire logic i2c_start_done,
   input wire logic i2c_stop_done,
   input wire logic i2c_restart_done,
   input wire logic i2c_ack_done,
   input wire logic bus_start_seen,
   input wire logic bus_stop_seen,
   input wire logic sync_serial_idle,

   // Capture/compare channel 1
   input wire logic [1:0] capcomp_mode,
   input wire logic capture_event,
   input wire logic compare_match,

   // Timers
   input wire logic [15:0] timer_a_count,
   input wire logic timer_b_tick,
   input wire logic [7:0] timer_b_count,
   input wire logic [7:0] timer_b_period,

   // Interrupt
   output logic irq
);

   // Sticky bank order, high to low
   localparam int sticky_w = 6;
   localparam int s_par = 5;
   localparam int s_adc = 4;
   localparam int s_sync = 3;
   localparam int s_ccp = 2;
   localparam int s_period = 1;
   localparam int s_ovf = 0;

   logic wr_en;
   logic [addr_w-1:0] reg_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_data;

   logic [sticky_w-1:0] sticky_set;
   logic [sticky_w-1:0] sticky_clr;
   logic [sticky_w-1:0] sticky_ff;

   logic [7:0] mask_ff;
   logic rx_level_ff;
   logic tx_level_ff;
   logic [15:0] timer_a_prev_ff;
   logic timer_a_valid_ff;
   logic irq_ff;

   logic [7:0] peripheral_irq_flags_1;
   logic [7:0] pending;
   logic sync_event;
   logic ccp_event;
   logic period_event;
   logic ovf_event;
   logic flags_wr_hit;
   logic mask_wr_hit;
   irq_flag_pkg::capcomp_mode_type ccp_mode;

   // Compare a bus address with a register offset
   function automatic logic reg_hit(
      input logic [addr_w-1:0] addr,
      input logic [3:0] ofs
   );
      reg_hit = (addr == addr_w'(ofs));
   endfunction : reg_hit

   avmm_reg_slave #(
      .addr_w(addr_w)
   ) u_slave (
      .ref_clk(ref_clk),
      .rst(rst),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .byteenable(byteenable),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .wr_en(wr_en),
      .reg_addr(reg_addr),
      .wr_data(wr_data),
      .rd_data(rd_data)
   );

   assign ccp_mode = irq_flag_pkg::capcomp_mode_type'(capcomp_mode);

   // Write strobes, one per writable register
   assign flags_wr_hit = wr_en & reg_hit(reg_addr, irq_flag_pkg::flags_ofs);
   assign mask_wr_hit = wr_en & reg_hit(reg_addr, irq_flag_pkg::mask_ofs);

   // Synchronous serial port sources merge into one flag;
   // several may pulse together, only one set results
   always_comb begin
      sync_event = 1'b0;
      // R5 SPI or slave transfer
      if (spi_xfer_done | i2c_slave_xfer_done) begin
         sync_event = 1'b1;
      end
      // R6 master sequences complete
      if (i2c_master_mode & (i2c_master_xfer_done | i2c_start_done |
            i2c_stop_done | i2c_restart_done | i2c_ack_done)) begin
         sync_event = 1'b1;
      end
      // R7 foreign START or STOP
      if (i2c_master_mode & sync_serial_idle &
            (bus_start_seen | bus_stop_seen)) begin
         sync_event = 1'b1;
      end
   end

   // Capture/compare source depends on channel mode
   always_comb begin
      case (ccp_mode)
         // R8 capture sets flag
         irq_flag_pkg::ccp_capture: begin
            ccp_event = capture_event;
         end
         // R9 compare match sets flag
         irq_flag_pkg::ccp_compare: begin
            ccp_event = compare_match;
         end
         // R9 PWM leaves it unused
         irq_flag_pkg::ccp_pwm: begin
            ccp_event = 1'b0;
         end
         // Channel off has no source
         irq_flag_pkg::ccp_off: begin
            ccp_event = 1'b0;
         end
         default: begin
            ccp_event = 1'b0;
         end
      endcase
   end

   // R10 count meets period
   assign period_event = timer_b_tick & (timer_b_count == timer_b_period);

   // R11 wrap from all ones to zero
   assign ovf_event = timer_a_valid_ff &
      (timer_a_prev_ff == irq_flag_pkg::timer_a_max) &
      (timer_a_count == 16'h0000);

   // Previous timer A value for wrap detection
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         timer_a_prev_ff <= 16'h0000;
         timer_a_valid_ff <= 1'b0;
      end else begin
         timer_a_prev_ff <= timer_a_count;
         timer_a_valid_ff <= 1'b1;
      end
   end

   // R12 enables never gate setting
   always_comb begin
      sticky_set = '0;
      // R1 port access sets
      sticky_set[s_par] = parallel_access_done;
      // R2 conversion done sets
      sticky_set[s_adc] = conversion_done;
      sticky_set[s_sync] = sync_event;
      sticky_set[s_ccp] = ccp_event;
      sticky_set[s_period] = period_event;
      sticky_set[s_ovf] = ovf_event;
   end

   // Write one to clear; bits 5 and 4 are not sticky
   always_comb begin
      sticky_clr = '0;
      // Zeros in the write leave their flags alone
      if (flags_wr_hit) begin
         sticky_clr[s_par] = wr_data[irq_flag_pkg::par_bit];
         sticky_clr[s_adc] = wr_data[irq_flag_pkg::adc_bit];
         // R5 software clears
         sticky_clr[s_sync] = wr_data[irq_flag_pkg::sync_bit];
         sticky_clr[s_ccp] = wr_data[irq_flag_pkg::ccp_bit];
         sticky_clr[s_period] = wr_data[irq_flag_pkg::period_bit];
         sticky_clr[s_ovf] = wr_data[irq_flag_pkg::ovf_bit];
      end
   end

   // R14 set wins inside bank
   sticky_flag_bank #(
      .width(sticky_w)
   ) u_flags (
      .ref_clk(ref_clk),
      .rst(rst),
      .set_in(sticky_set),
      .clr_in(sticky_clr),
      .flags_ff(sticky_ff)
   );

   // Buffer levels follow the serial port, one cycle late
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_level_ff <= irq_flag_pkg::flags_rst[irq_flag_pkg::rx_bit];
         tx_level_ff <= irq_flag_pkg::flags_rst[irq_flag_pkg::tx_bit];
      end else begin
         // R3 receive buffer full
         rx_level_ff <= rx_buffer_full;
         // R4 transmit buffer empty
         tx_level_ff <= tx_buffer_empty;
      end
   end

   // Assemble the visible flag register
   always_comb begin
      peripheral_irq_flags_1 = 8'h00;
      peripheral_irq_flags_1[irq_flag_pkg::par_bit] = sticky_ff[s_par];
      peripheral_irq_flags_1[irq_flag_pkg::adc_bit] = sticky_ff[s_adc];
      peripheral_irq_flags_1[irq_flag_pkg::rx_bit] = rx_level_ff;
      peripheral_irq_flags_1[irq_flag_pkg::tx_bit] = tx_level_ff;
      peripheral_irq_flags_1[irq_flag_pkg::sync_bit] = sticky_ff[s_sync];
      peripheral_irq_flags_1[irq_flag_pkg::ccp_bit] = sticky_ff[s_ccp];
      peripheral_irq_flags_1[irq_flag_pkg::period_bit] = sticky_ff[s_period];
      peripheral_irq_flags_1[irq_flag_pkg::ovf_bit] = sticky_ff[s_ovf];
   end

   // Interrupt mask
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mask_ff <= irq_flag_pkg::mask_rst;
      end else if (mask_wr_hit) begin
         mask_ff <= wr_data;
      end
   end

   // Stale flags fire as soon as the mask opens;
   // software must clear them before unmasking
   assign pending = peripheral_irq_flags_1 & mask_ff;

   // Registered level interrupt; levels of bits 5 and 4 pass too
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |pending;
      end
   end

   assign irq = irq_ff;

   // Read mux; unmapped offsets read zero
   always_comb begin
      rd_data = 8'h00;
      if (reg_hit(reg_addr, irq_flag_pkg::flags_ofs)) begin
         rd_data = peripheral_irq_flags_1;
      end else if (reg_hit(reg_addr, irq_flag_pkg::mask_ofs)) begin
         rd_data = mask_ff;
      end else if (reg_hit(reg_addr, irq_flag_pkg::pending_ofs)) begin
         rd_data = pending;
      end
   end

endmodule : periph_irq_flags

// ===== irq_flag_pkg.sv
// Constants shared by the peripheral interrupt flag block.
// Assumes a 32-bit Avalon-MM register bus with byte addressing.
package irq_flag_pkg;

   // Register byte offsets
   localparam logic [3:0] flags_ofs = 4'h0;
   localparam logic [3:0] mask_ofs = 4'h4;
   localparam logic [3:0] pending_ofs = 4'h8;

   // Flag positions in the flag register
   localparam int par_bit = 7;
   localparam int adc_bit = 6;
   localparam int rx_bit = 5;
   localparam int tx_bit = 4;
   localparam int sync_bit = 3;
   localparam int ccp_bit = 2;
   localparam int period_bit = 1;
   localparam int ovf_bit = 0;

   // Reset values
   localparam logic [7:0] flags_rst = 8'h00;
   localparam logic [7:0] mask_rst = 8'h00;

   // Timer A wraps after this count
   localparam logic [15:0] timer_a_max = 16'hffff;

   // Capture/compare channel 1 operating mode
   typedef enum logic [1:0] {
      ccp_off = 2'b00,
      ccp_capture = 2'b01,
      ccp_compare = 2'b10,
      ccp_pwm = 2'b11
   } capcomp_mode_type;

endpackage : irq_flag_pkg

// ===== sticky_flag_bank.sv
// Bank of sticky flags: hardware sets, software clears by writing one.
// Assumes set and clear are one-cycle strobes on ref_clk.
`timescale 1ns/1ps
module sticky_flag_bank #(
   parameter int width = 6
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Set and clear strobes
   input wire logic [width-1:0] set_in,
   input wire logic [width-1:0] clr_in,
   // Flag state
   output logic [width-1:0] flags_ff
);

   logic [width-1:0] nxt_flags;

   // R14 set beats clear
   always_comb begin
      nxt_flags = (flags_ff & ~clr_in) | set_in;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flags_ff <= '0;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

endmodule : sticky_flag_bank

// ===== avmm_reg_slave.sv
// Avalon-MM slave front end with one wait state per access.
// Assumes the master holds its request until waitrequest is low.
`timescale 1ns/1ps
module avmm_reg_slave #(
   parameter int addr_w = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [addr_w-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Register file side
   output logic wr_en,
   output logic [addr_w-1:0] reg_addr,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data
);

   logic ack_ff;

   // Answer one cycle after the request appears
   assign waitrequest = (read | write) & ~ack_ff;
   // Only byte lane 0 carries register bits
   assign wr_en = write & ack_ff & byteenable[0];
   assign reg_addr = address;
   assign wr_data = writedata[7:0];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (read | write) & ~ack_ff;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         readdata <= 32'h00000000;
      end else if (read & ~ack_ff) begin
         readdata <= {24'h000000, rd_data};
      end
   end

endmodule : avmm_reg_slave

// ===== irq_flag_checker_properties.sv
// Bus timing and flag checker for the peripheral interrupt flag block.
// Assumes one wait state per access and one-cycle event pulses.
`timescale 1ns/1ps
module irq_flag_checker #(
   parameter int addr_w = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register bus
   input wire logic [addr_w-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // Events
   input wire logic parallel_access_done,
   input wire logic conversion_done,
   input wire logic [1:0] capcomp_mode,
   input wire logic capture_event,
   input wire logic timer_b_tick,
   input wire logic [7:0] timer_b_count,
   input wire logic [7:0] timer_b_period,
   // Interrupt
   input wire logic irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic rd_go;
   assign rd_go = read && waitrequest && address == irq_flag_pkg::flags_ofs;

   wait_first_a: assert property ($rose(read || write) |-> waitrequest)
      else $error("first request cycle not stalled");
   one_wait_a: assert property ((read || write) && waitrequest |=>
      !waitrequest) else $error("wait state longer than one cycle");
   rdata_hold_a: assert property (!$past(read && waitrequest) && !$past(rst)
      |-> $stable(readdata)) else $error("read data moved without a read");
   irq_reset_a: assert property ($past(rst) |-> !irq)
      else $error("interrupt high right after reset");
   par_flag_a: assert property (
      parallel_access_done ##1 rd_go |=> readdata[7])
      else $error("parallel port flag not seen");
   upper_zero_a: assert property (readdata[31:8] == 24'h000000)
      else $error("read data upper bytes not zero");
   conv_flag_a: assert property (
      conversion_done ##1 rd_go |=> readdata[6])
      else $error("conversion flag not seen");
   capture_flag_a: assert property (
      capcomp_mode == irq_flag_pkg::ccp_capture && capture_event ##1 rd_go
      |=> readdata[2]) else $error("capture flag not seen");
   period_flag_a: assert property (
      timer_b_tick && timer_b_count == timer_b_period ##1 rd_go
      |=> readdata[1]) else $error("period match flag not seen");
endmodule : irq_flag_checker

bind periph_irq_flags irq_flag_checker #(.addr_w(addr_w)) chk_i (.*);

// ===== periph_event_src.sv
// Peripheral event source model: one-cycle event pulses.
// Assumes fire is called just after a rising ref_clk edge.
`timescale 1ns/1ps
module periph_event_src (
   // Clock
   input wire logic ref_clk,
   // Event pulses
   output logic [13:0] ev
);
   initial ev = '0;
   task automatic fire(input int i);
      ev <= 14'h1 << i;
      @(posedge ref_clk);
      ev <= '0;
   endtask : fire
endmodule : periph_event_src

// ===== periph_irq_flags_tb.sv
// Testbench for the peripheral interrupt flag block.
// Assumes the checker is bound in and events come from the source model.
`timescale 1ns/1ps
module periph_irq_flags_tb;
   logic ref_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
   logic [3:0] address = '0, byteenable = '0;
   logic [31:0] writedata = '0, readdata, d;
   logic waitrequest, irq, i2c_master_mode = 1'b0, sync_serial_idle = 1'b0;
   logic rx_buffer_full = 1'b0, tx_buffer_empty = 1'b0;
   logic [1:0] capcomp_mode = 2'h1;
   logic [15:0] timer_a_count = '0;
   logic [7:0] timer_b_count = 8'h06, timer_b_period = 8'h06;
   logic [13:0] ev;
   int error_cnt = 0, n_compared = 0;
   // Event order: parallel conv spi slave mxfer start stop restart ack
   // bus_start bus_stop capture compare tick
   localparam logic [7:0] exp_tab [3][14] = '{
      '{8'h80, 8'h40, 8'h08, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h04, 8'h00, 8'h02},
      '{8'h80, 8'h40, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08,
        8'h08, 8'h08, 8'h00, 8'h04, 8'h00},
      '{8'h80, 8'h40, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h02}};
   localparam logic [1:0] mode_tab [3] = '{2'h1, 2'h2, 2'h3};

   periph_event_src src (.ref_clk(ref_clk), .ev(ev));
   periph_irq_flags dut (.*, .parallel_access_done(ev[0]),
      .conversion_done(ev[1]), .spi_xfer_done(ev[2]),
      .i2c_slave_xfer_done(ev[3]), .i2c_master_xfer_done(ev[4]),
      .i2c_start_done(ev[5]), .i2c_stop_done(ev[6]),
      .i2c_restart_done(ev[7]), .i2c_ack_done(ev[8]),
      .bus_start_seen(ev[9]), .bus_stop_seen(ev[10]),
      .capture_event(ev[11]), .compare_match(ev[12]), .timer_b_tick(ev[13]));

   always #4 ref_clk = ~ref_clk;

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
         input logic [7:0] wd, input logic [3:0] be);
      @(posedge ref_clk);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= {24'h0, wd};
      byteenable <= be;
      // Loops until waitrequest is sampled low
      do begin
         @(posedge ref_clk);
      end while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00, 4'hf);
      chk(d, {24'h0, exp});
   endtask : rd_chk

   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk(4'h0, 8'h00);
      rd_chk(4'h4, 8'h00);
      rd_chk(4'hc, 8'h00);
      for (int p = 0; p < 3; p++) begin
         @(posedge ref_clk);
         i2c_master_mode <= p > 0;
         sync_serial_idle <= p == 1;
         capcomp_mode <= mode_tab[p];
         timer_b_count <= (p == 1) ? 8'h05 : 8'h06;
         for (int i = 0; i < 14; i++) begin
            fork
               src.fire(i);
               bus(1'b0, 4'h0, 8'h00, 4'hf);
            join
            chk(d, {24'h0, exp_tab[p][i]});
            bus(1'b1, 4'h0, 8'hff, 4'hf);
         end
      end
      @(posedge ref_clk);
      capcomp_mode <= 2'h0;
      src.fire(11);
      @(posedge ref_clk);
      src.fire(12);
      rd_chk(4'h0, 8'h00);
      @(posedge ref_clk);
      timer_a_count <= 16'hffff;
      @(posedge ref_clk);
      timer_a_count <= 16'h0000;
      rd_chk(4'h0, 8'h01);
      bus(1'b1, 4'h0, 8'hff, 4'hf);
      rx_buffer_full <= 1'b1;
      rd_chk(4'h0, 8'h20);
      bus(1'b1, 4'h0, 8'hff, 4'hf);
      rd_chk(4'h0, 8'h20);
      rx_buffer_full <= 1'b0;
      tx_buffer_empty <= 1'b1;
      rd_chk(4'h0, 8'h10);
      tx_buffer_empty <= 1'b0;
      src.fire(1);
      rd_chk(4'h0, 8'h40);
      chk(irq, 1'b0);
      bus(1'b1, 4'h0, 8'h40, 4'hf);
      bus(1'b1, 4'h4, 8'h40, 4'hf);
      rd_chk(4'h4, 8'h40);
      chk(irq, 1'b0);
      src.fire(1);
      rd_chk(4'h8, 8'h40);
      chk(irq, 1'b1);
      bus(1'b1, 4'h0, 8'h40, 4'hf);
      repeat (2) @(posedge ref_clk);
      chk(irq, 1'b0);
      fork
         bus(1'b1, 4'h0, 8'h80, 4'hf);
         begin
            repeat (2) @(posedge ref_clk);
            src.fire(0);
         end
      join
      rd_chk(4'h0, 8'h80);
      bus(1'b1, 4'h0, 8'hff, 4'hf);
      src.fire(1);
      bus(1'b1, 4'h0, 8'hff, 4'he);
      bus(1'b1, 4'hc, 8'hff, 4'hf);
      rd_chk(4'h0, 8'h40);
      rd_chk(4'hc, 8'h00);
      final_report();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge ref_clk);
      error_cnt++;
      final_report();
   end
endmodule : periph_irq_flags_tb
